// File: hdl/gpt_top.sv
// Purpose: Two independent 16-bit general timers behind an APB slave.
// Assumes: Source and mask pins are asynchronous levels; sources are slow vs pclk.
// Notes:   Zero-wait APB; prdata, pready and pslverr are registered.
`timescale 1ns/1ps
`default_nettype none
module gpt_top (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer clock sources
    input wire logic rc_clk_1khz,
    input wire logic xtal_clk_32k,
    input wire logic main_clk_12m,
    input wire logic first_external_clock_pin,
    input wire logic second_external_clock_pin,
    // Gate mask pins
    input wire logic first_gate_mask_pin,
    input wire logic second_gate_mask_pin,
    // Count values
    output logic [gpt_pkg::GPT_NUM_TIMERS-1:0][gpt_pkg::GPT_CW-1:0]
        timer_count
);
    import gpt_pkg::*;

    gpt_top_st_t s;
    gpt_top_st_t n;

    logic [GPT_NUM_TIMERS-1:0][GPT_NSRC-1:0] src_raw;
    logic [GPT_NUM_TIMERS-1:0] ext_clk;
    logic [GPT_NUM_TIMERS-1:0] src_edge;
    logic [GPT_NUM_TIMERS-1:0] tick;

    assign ext_clk = {second_external_clock_pin, first_external_clock_pin};

    // One tick generator per timer; both are the same block
    genvar g;
    generate
        for (g = 0; g < GPT_NUM_TIMERS; g++) begin : g_tmr
            // Source vector order follows the source codes
            assign src_raw[g][GPT_SRC_RC_1K] = rc_clk_1khz;
            assign src_raw[g][GPT_SRC_XTAL_32K] = xtal_clk_32k;
            assign src_raw[g][GPT_SRC_MAIN_12M] = main_clk_12m;
            assign src_raw[g][GPT_SRC_EXTERNAL] = ext_clk[g];

            gpt_tick u_tick (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .src_raw(src_raw[g]),
                .act(s.act[g]),
                .src_edge(src_edge[g]),
                .tick(tick[g])
            );
        end
    endgenerate

    // Next-state logic: timers first, then the bus
    always_comb begin
        logic gate_ok;
        logic setup;
        logic access;
        logic hit;
        logic [0:0] ti;
        logic [1:0] ri;
        gpt_cfg_t wcfg;
        gpt_stat_t st;
        gate_ok = 1'b0;
        setup = 1'b0;
        access = 1'b0;
        hit = 1'b0;
        ti = 1'b0;
        ri = 2'h0;
        wcfg = '0;
        st = '0;
        n = s;

        // Mask pin synchroniser; first stage feeds only the second
        n.gate_meta = {second_gate_mask_pin, first_gate_mask_pin};
        n.gate_sync = s.gate_meta;

        for (int t = 0; t < GPT_NUM_TIMERS; t++) begin
            // Configuration settings reach the counter only at a source edge
            if (src_edge[t]) begin
                n.act[t] = s.cfg[t];
            end
            n.en_prev[t] = s.act[t].count_enable;

            // Pin is consulted only when the gate bit is set
            gate_ok = !s.act[t].external_gate_check
                || s.gate_sync[t];

            if (!s.act[t].count_enable) begin
                // Disabled: count held, a finished pass is re-armed
                n.done[t] = 1'b0;
            end else if (!s.en_prev[t]) begin
                // Fresh enable loads the initial direction
                n.dir_down[t] = s.act[t].initial_direction_down;
            end else if (tick[t] && gate_ok && !s.done[t]) begin
                if (s.dir_down[t]) begin
                    if (s.cnt[t] == GPT_COUNT_ZERO) begin
                        if (s.act[t].single_pass) begin
                            n.done[t] = 1'b1;
                        end else if (s.act[t].alternating_mode) begin
                            // Turn round at zero
                            n.dir_down[t] = 1'b0;
                            if (s.top[t] != GPT_COUNT_ZERO) begin
                                n.cnt[t] = GPT_COUNT_ONE;
                            end
                        end else begin
                            n.cnt[t] = s.top[t];
                        end
                    end else begin
                        n.cnt[t] = s.cnt[t] - GPT_COUNT_ONE;
                    end
                end else begin
                    if (s.cnt[t] == s.top[t]) begin
                        if (s.act[t].single_pass) begin
                            n.done[t] = 1'b1;
                        end else if (s.act[t].alternating_mode) begin
                            // Turn round at the threshold
                            n.dir_down[t] = 1'b1;
                            if (s.cnt[t] != GPT_COUNT_ZERO) begin
                                n.cnt[t] = s.cnt[t] - GPT_COUNT_ONE;
                            end
                        end else begin
                            n.cnt[t] = GPT_COUNT_ZERO;
                        end
                    end else begin
                        n.cnt[t] = s.cnt[t] + GPT_COUNT_ONE;
                    end
                end
            end
        end

        // APB decode
        setup = psel && !penable;
        access = psel && penable && s.pready;
        hit = gpt_mapped(paddr);
        ti = paddr[GPT_TMR_BIT];
        ri = paddr[GPT_REG_MSB:GPT_REG_LSB];
        n.pready = 1'b0;
        n.pslverr = 1'b0;

        // Setup phase: answer is prepared so access needs no wait
        if (setup) begin
            n.pready = 1'b1;
            n.pslverr = !hit;
            n.prdata = '0;
            if (hit && !pwrite) begin
                unique case (ri)
                    GPT_REG_CONFIG: begin
                        n.prdata[GPT_CW-1:0] = s.cfg[ti];
                    end
                    GPT_REG_THRESHOLD: begin
                        n.prdata[GPT_CW-1:0] = s.top[ti];
                    end
                    GPT_REG_COUNT: begin
                        n.prdata[GPT_CW-1:0] = s.cnt[ti];
                    end
                    GPT_REG_STATUS: begin
                        st.dir_down = s.dir_down[ti];
                        st.pass_done = s.done[ti];
                        st.running = s.act[ti].count_enable && !s.done[ti]
                            && (!s.act[ti].external_gate_check
                            || s.gate_sync[ti]);
                        n.prdata[GPT_CW-1:0] = st;
                    end
                endcase
            end
        end

        // Access phase: writes land on the edge that sees pready
        if (access && pwrite && hit) begin
            unique case (ri)
                GPT_REG_CONFIG: begin
                    wcfg = pwdata[GPT_CW-1:0];
                    wcfg.reserved = '0;
                    if (s.cfg[ti].count_enable) begin
                        // While running only the enable bit may change
                        n.cfg[ti].count_enable = wcfg.count_enable;
                    end else begin
                        n.cfg[ti] = wcfg;
                    end
                end
                GPT_REG_THRESHOLD: begin
                    n.top[ti] = pwdata[GPT_CW-1:0];
                end
                GPT_REG_COUNT: begin
                    // Load only while fully stopped, so ticks never race it
                    if (!s.cfg[ti].count_enable
                        && !s.act[ti].count_enable) begin
                        n.cnt[ti] = pwdata[GPT_CW-1:0];
                    end
                end
                GPT_REG_STATUS: begin
                    // Status is read only; write is ignored
                end
            endcase
        end
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    // Outputs straight from the state flops
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign timer_count = s.cnt;

endmodule
`default_nettype wire

// File: hdl/gpt_pkg.sv
// Purpose: Shared constants and carrier types for the dual general timer.
// Assumes: 32-bit APB register window, one word per register.
// Notes:   Timer 0 sits in the low half of the window, timer 1 above it.
package gpt_pkg;

    // Geometry
    localparam int GPT_NUM_TIMERS = 2;
    localparam int GPT_CW = 16;
    localparam int GPT_DIVW = 10;
    localparam int GPT_NSRC = 4;

    // Prescale exponent saturates at this value
    localparam logic [3:0] GPT_EXP_MAX = 4'ha;

    // Clock source codes (also the index into the source vector)
    localparam logic [1:0] GPT_SRC_RC_1K = 2'h0;
    localparam logic [1:0] GPT_SRC_XTAL_32K = 2'h1;
    localparam logic [1:0] GPT_SRC_MAIN_12M = 2'h2;
    localparam logic [1:0] GPT_SRC_EXTERNAL = 2'h3;

    // APB address map (byte addresses)
    localparam logic [31:0] GPT_MAP_SIZE = 32'h0000_0020;
    localparam int GPT_TMR_BIT = 4;
    localparam int GPT_REG_MSB = 3;
    localparam int GPT_REG_LSB = 2;
    localparam logic [1:0] GPT_REG_CONFIG = 2'h0;
    localparam logic [1:0] GPT_REG_THRESHOLD = 2'h1;
    localparam logic [1:0] GPT_REG_COUNT = 2'h2;
    localparam logic [1:0] GPT_REG_STATUS = 2'h3;
    localparam logic [1:0] GPT_ALIGN_ZERO = 2'h0;

    // Reset values and count constants
    localparam logic [GPT_CW-1:0] GPT_THRESHOLD_RST = 16'h0000;
    localparam logic [GPT_CW-1:0] GPT_COUNT_RST = 16'h0000;
    localparam logic [GPT_CW-1:0] GPT_COUNT_ZERO = 16'h0000;
    localparam logic [GPT_CW-1:0] GPT_COUNT_ONE = 16'h0001;

    // Configuration word layout
    typedef struct packed {
        logic [2:0] reserved;
        logic external_gate_check;
        logic count_enable;
        logic alternating_mode;
        logic initial_direction_down;
        logic single_pass;
        logic [3:0] prescale_exponent;
        logic input_glitch_filter;
        logic clock_edge_select;
        logic [1:0] clock_source_select;
    } gpt_cfg_t;

    // Status word layout
    typedef struct packed {
        logic [12:0] reserved;
        logic dir_down;
        logic pass_done;
        logic running;
    } gpt_stat_t;

    // State of one tick generator
    typedef struct packed {
        logic [GPT_NSRC-1:0] meta;
        logic [GPT_NSRC-1:0] sync;
        logic src_prev;
        logic [GPT_DIVW-1:0] div;
        logic div_prev;
        logic edge_q;
        logic tick_q;
    } gpt_tick_st_t;

    // State of the top level
    typedef struct packed {
        logic [GPT_NUM_TIMERS-1:0] gate_meta;
        logic [GPT_NUM_TIMERS-1:0] gate_sync;
        gpt_cfg_t [GPT_NUM_TIMERS-1:0] cfg;
        gpt_cfg_t [GPT_NUM_TIMERS-1:0] act;
        logic [GPT_NUM_TIMERS-1:0][GPT_CW-1:0] top;
        logic [GPT_NUM_TIMERS-1:0][GPT_CW-1:0] cnt;
        logic [GPT_NUM_TIMERS-1:0] dir_down;
        logic [GPT_NUM_TIMERS-1:0] done;
        logic [GPT_NUM_TIMERS-1:0] en_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } gpt_top_st_t;

    // Effective prescale exponent: 11..15 behave as 10
    function automatic logic [3:0] gpt_eff_exp(input logic [3:0] n);
        gpt_eff_exp = (n > GPT_EXP_MAX) ? GPT_EXP_MAX : n;
    endfunction

    // Address is inside the window and word aligned
    function automatic logic gpt_mapped(input logic [31:0] a);
        gpt_mapped = (a < GPT_MAP_SIZE) && (a[1:0] == GPT_ALIGN_ZERO);
    endfunction

endpackage

// File: hdl/gpt_tick.sv
// Purpose: Per-timer clock source select, prescaler and edge select.
// Assumes: Source clocks are far slower than pclk and sampled as levels.
// Notes:   Emits one-cycle pulses: tick advances the counter, src_edge
//          marks any edge of the selected source.
`timescale 1ns/1ps
`default_nettype none
module gpt_tick (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Raw source levels, indexed by source code
    input wire logic [gpt_pkg::GPT_NSRC-1:0] src_raw,
    // Active configuration
    input wire gpt_pkg::gpt_cfg_t act,
    // Pulses
    output logic src_edge,
    output logic tick
);
    import gpt_pkg::*;

    gpt_tick_st_t s;
    gpt_tick_st_t n;

    // Next-state logic
    always_comb begin
        logic sel;
        logic rise;
        logic lvl;
        logic [3:0] e;
        sel = 1'b0;
        rise = 1'b0;
        lvl = 1'b0;
        e = 4'h0;
        n = s;
        // Two-stage synchroniser, first stage feeds only the second
        n.meta = src_raw;
        n.sync = s.meta;
        // Source multiplexer
        sel = s.sync[act.clock_source_select];
        rise = sel & ~s.src_prev;
        n.src_prev = sel;
        n.edge_q = sel ^ s.src_prev;
        // Divider counts source rising edges
        if (rise) begin
            n.div = s.div + 10'h001;
        end
        // Divided level: bit N-1 of the counter toggles at source/2^N
        e = gpt_eff_exp(act.prescale_exponent);
        if (e == 4'h0) begin
            lvl = sel;
        end else begin
            lvl = s.div[e - 4'h1];
        end
        n.div_prev = lvl;
        // Edge select on the divided clock
        if (act.clock_edge_select) begin
            n.tick_q = ~lvl & s.div_prev;
        end else begin
            n.tick_q = lvl & ~s.div_prev;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign src_edge = s.edge_q;
    assign tick = s.tick_q;

endmodule
`default_nettype wire

// File: tb/gpt_top_asserts.sv
// Purpose: Concurrent checks on the APB answer and the count pacing.
// Assumes: Sees only the ports of the timer top level.
// Notes:   Counts are checked for pace, not value; the bench does values.
`timescale 1ns/1ps
`default_nettype none
module gpt_top_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Counts
    input wire logic [gpt_pkg::GPT_NUM_TIMERS-1:0][gpt_pkg::GPT_CW-1:0]
        timer_count
);
    import gpt_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup phase, split by whether the address is a register word
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad;
        s_setup ##0 (paddr >= GPT_MAP_SIZE || paddr[1:0] != 2'h0);
    endsequence
    sequence s_good;
        s_setup ##0 (paddr < GPT_MAP_SIZE && paddr[1:0] == 2'h0);
    endsequence
    a_ready_follows: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    a_ready_idle: assert property (!(psel && !penable) |=> !pready)
        else $error("answer without setup");
    a_err_bad: assert property (s_bad |=> pslverr && pready)
        else $error("bad address not refused");
    a_err_good: assert property (s_good |=> !pslverr)
        else $error("good address refused");
    a_write_zero: assert property (s_setup ##0 pwrite |=> prdata == '0)
        else $error("read data not zero on write");
    a_rdata_stands: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    // Ticks come at most once per two source samples, so no back to back
    a_pace_first: assert property (
        $changed(timer_count[0]) |=> $stable(timer_count[0]))
        else $error("first count moved twice in a row");
    a_pace_second: assert property (
        $changed(timer_count[1]) |=> $stable(timer_count[1]))
        else $error("second count moved twice in a row");
endmodule
`default_nettype wire

// File: tb/gpt_top_tb.sv
// Purpose: Self-checking bench for the dual general timer.
// Assumes: Zero-wait APB; every timer source is a bench-made square.
// Notes:   One free counter makes all sources, so tick spacing is known.
`timescale 1ns/1ps
`default_nettype none
module gpt_top_tb;
    import gpt_pkg::*;
    // Bench state
    logic pclk, presetn, psel, penable, pwrite, er, gate0, gate1;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic pready, pslverr;
    logic [8:0] fc = '0;
    logic [15:0] v;
    logic [GPT_NUM_TIMERS-1:0][GPT_CW-1:0] timer_count;
    int err_count, cmp_count, n;
    // Config word and expected tick spacing in pclk cycles
    logic [31:0] cf [7] = '{32'h0802, 32'h0800, 32'h0801, 32'h0803,
        32'h0810, 32'h08b0, 32'h0804};
    int pe [7] = '{4, 8, 16, 512, 16, 8192, 8};
    gpt_top dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rc_clk_1khz(fc[2]), .xtal_clk_32k(fc[3]), .main_clk_12m(fc[1]),
        .first_external_clock_pin(fc[8]),
        .second_external_clock_pin(fc[8]),
        .first_gate_mask_pin(gate0), .second_gate_mask_pin(gate1),
        .timer_count(timer_count));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Sources share one counter: periods 4, 8 and 16 cycles; the external
    // pin gets 512 cycles, about 98 kHz, to stay under its pin limit
    always @(posedge pclk) fc <= fc + 9'h001;
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; pready is sampled at the rising edge, as a master
    // sees it, and the request is released right after that edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            err_count++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [31:0] a, exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Waits for the next count change, giving up after lim cycles
    task automatic nxt(input int t, lim);
        logic [15:0] p;
        p = timer_count[t];
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (timer_count[t] === p && n < lim);
        v = timer_count[t];
    endtask
    // Same, but a count that never moves is a mismatch and ends the run
    task automatic nxtw(input int t, lim);
        nxt(t, lim);
        if (n >= lim) begin
            err_count++;
            summarize();
        end
    endtask
    task automatic seq(input int t, input logic [63:0] e, input int k);
        for (int i = 0; i < k; i++) begin
            nxtw(t, 1200);
            chk({16'h0, v}, {16'h0, e[63 - 16 * i -: 16]});
        end
    endtask
    task automatic load(input int t, input logic [15:0] th, c,
        input logic [31:0] cfg);
        wr(32'(t * 16 + 4), {16'h0, th});
        wr(32'(t * 16 + 8), {16'h0, c});
        wr(32'(t * 16), cfg);
    endtask
    // Disabling lands at a source edge; wait past the slowest one
    task automatic stop(input int t);
        wr(32'(t * 16), 32'h0);
        repeat (400) @(posedge pclk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, gate0, gate1} = '0;
        paddr = '0;
        pwdata = '0;
        err_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then refused addresses
        for (int a = 0; a < 32; a += 4) begin
            rdc(32'(a), 32'h0);
        end
        apb(1'b0, 32'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, 32'h2, 32'h0);
        chk({31'h0, er}, 32'h1);
        wr(32'h10, 32'hffff_f7f7);
        rdc(32'h10, 32'h0000_17f7);
        wr(32'h10, 32'h0);
        // Repeating up, the count holds once disabled, then alternating and repeating down
        load(0, 16'h3, 16'h0, 32'h0802);
        seq(0, 64'h0001_0002_0003_0000, 4);
        stop(0);
        v = timer_count[0];
        repeat (100) @(posedge pclk);
        chk({16'h0, timer_count[0]}, {16'h0, v});
        load(0, 16'h2, 16'h0, 32'h0c02);
        seq(0, 64'h0001_0002_0001_0000, 4);
        stop(0);
        load(1, 16'h3, 16'h2, 32'h0a03);
        seq(1, 64'h0001_0000_0003_0002, 4);
        stop(1);
        // Single pass ends at the threshold and stays there
        load(1, 16'h2, 16'h0, 32'h0902);
        seq(1, 64'h0001_0002_0000_0000, 2);
        nxt(1, 300);
        chk(32'(n), 32'd300);
        apb(1'b0, 32'h1c, 32'h0);
        chk(rd & 32'h2, 32'h2);
        stop(1);
        // Gate bit set with the mask pin low blocks counting
        load(0, 16'hffff, 16'h0, 32'h1802);
        nxt(0, 300);
        chk(32'(n), 32'd300);
        @(posedge pclk);
        gate0 <= 1'b1;
        seq(0, 64'h0001_0000_0000_0000, 1);
        stop(0);
        // Source, prescale and edge choices set the tick spacing
        for (int i = 0; i < 7; i++) begin
            load(0, 16'hffff, 16'h0, cf[i]);
            nxtw(0, 10000);
            nxtw(0, 10000);
            chk(32'(n), 32'(pe[i]));
            stop(0);
        end
        summarize();
    end
endmodule
bind gpt_top gpt_top_chk chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_count(timer_count));
`default_nettype wire
